// File: dv/tb_top.sv
// Purpose: self-checking bench for the periodic down timer over ahb-lite
// Assumes: single slave, hready fed back from hreadyout, reads take a wait state
// Notes:   driver queues expected results, a monitor pops them as results appear
`timescale 1ns/10ps
`include "pdt_cfg.svh"

module tb_top;
    typedef struct {
        string       nm;
        logic [31:0] exp;
        logic [31:0] tol;
    } pdt_note_t;

    // clock, reset and bus
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    // bench state
    pdt_note_t   notes[$];
    logic        probe;
    logic        rd_dp = 1'b0;
    logic [31:0] l1;
    logic [7:0]  p1;
    logic [7:0]  p2;
    int          n_errors;
    int          n_tests;

    pdt_timer uut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .irq       (irq)
    );

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // 200 mhz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic give_verdict();
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // pop oldest note; a tolerance covers divider phase we cannot know
    task automatic chk(input logic [31:0] seen);
        pdt_note_t nt;
        n_tests++;
        if (notes.size() == 0) begin
            n_errors++;
            $display("ERROR unexpected result expected none seen %h", seen);
            return;
        end
        nt = notes.pop_front();
        if (nt.tol == 32'h0 ? (seen !== nt.exp) : ((^seen) === 1'bx ||
            seen + nt.tol < nt.exp || seen > nt.exp + nt.tol)) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nt.nm, nt.exp, seen);
        end
    endtask

    // monitor: read data at the edge ending a read data phase, irq on probe
    always @(posedge hclk) begin
        if (rd_dp && hready) begin
            chk(hrdata);
            n_tests++;
            if (hresp !== 1'b0) begin
                n_errors++;
                $display("ERROR hresp expected 0 seen %b", hresp);
            end
            rd_dp = 1'b0;
        end
        if (hsel && htrans[1] && hready && !hwrite) rd_dp = 1'b1;
        if (probe) chk({31'h0, irq});
    end

    // one single word transfer, held until ready is sampled high
    task automatic bus(input logic wr, input logic [4:0] off, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= `PDT_BASE_ADDR | {27'h0, off};
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (n >= 50) begin
            n_errors++;
            $display("ERROR bus ready expected 1 seen stuck");
            give_verdict();
        end
    endtask

    task automatic rd(input string nm, input logic [4:0] off, input logic [31:0] exp,
                      input logic [31:0] tol);
        notes.push_back('{nm, exp, tol});
        bus(1'b0, off, 32'h0);
    endtask

    task automatic probe_irq(input logic e);
        notes.push_back('{"irq", {31'h0, e}, 32'h0});
        @(posedge hclk);
        probe <= 1'b1;
        @(posedge hclk);
        probe <= 1'b0;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        $display("ERROR run length expected end seen timeout");
        give_verdict();
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        probe = 1'b0;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(32'h817797a3));
        l1 = 32'h8 + ($urandom % 16);
        // prescale one fixed here so the every-second-cycle case always runs
        p1 = 8'h01;
        p2 = 8'($urandom % 8);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values of the registers and the interrupt
        probe_irq(1'b0);
        rd("load", `PDT_OFF_LOAD, 32'h0, 32'h0);
        rd("count", `PDT_OFF_COUNT, 32'h0, 32'h0);
        rd("ctrl", `PDT_OFF_CTRL, 32'h0, 32'h0);
        rd("stat", `PDT_OFF_STAT, 32'h0, 32'h0);
        // load first, so stray writes after it would show in the reads below
        bus(1'b1, `PDT_OFF_LOAD, l1);
        bus(1'b1, 5'h18, $urandom);
        bus(1'b1, `PDT_OFF_COUNT, $urandom);
        rd("count", `PDT_OFF_COUNT, l1, 32'h0);
        rd("unmapped", 5'h18, 32'h0, 32'h0);
        rd("load", `PDT_OFF_LOAD, l1, 32'h0);
        // one-shot run to zero, irq still masked
        bus(1'b1, `PDT_OFF_CTRL, {16'h0, p1, 8'h01});
        rd("ctrl", `PDT_OFF_CTRL, {16'h0, p1, 8'h01}, 32'h0);
        repeat (l1 * (p1 + 1) + 10) @(posedge hclk);
        rd("count", `PDT_OFF_COUNT, 32'h0, 32'h0);
        rd("stat", `PDT_OFF_STAT, 32'h1, 32'h0);
        probe_irq(1'b0);
        // interrupt raised, masked, cleared
        bus(1'b1, `PDT_OFF_IEN, 32'h1);
        rd("ctrl", `PDT_OFF_CTRL, {16'h0, p1, 8'h05}, 32'h0);
        probe_irq(1'b1);
        bus(1'b1, `PDT_OFF_STAT, 32'h0);
        rd("stat", `PDT_OFF_STAT, 32'h1, 32'h0);
        bus(1'b1, `PDT_OFF_IEN, 32'h0);
        probe_irq(1'b0);
        bus(1'b1, `PDT_OFF_IEN, 32'h1);
        probe_irq(1'b1);
        bus(1'b1, `PDT_OFF_CLR, 32'h1);
        rd("stat", `PDT_OFF_STAT, 32'h0, 32'h0);
        rd("clr", `PDT_OFF_CLR, 32'h0, 32'h0);
        probe_irq(1'b0);
        // prescaled run of about 43 enabled edges, then hold
        bus(1'b1, `PDT_OFF_CTRL, 32'h0);
        bus(1'b1, `PDT_OFF_LOAD, 32'd1000);
        bus(1'b1, `PDT_OFF_CTRL, {16'h0, p2, 8'h01});
        repeat (40) @(posedge hclk);
        bus(1'b1, `PDT_OFF_CTRL, {16'h0, p2, 8'h00});
        rd("count", `PDT_OFF_COUNT, 32'd1000 - 32'(43 / (p2 + 1)), 32'h1);
        repeat (30) @(posedge hclk);
        rd("count", `PDT_OFF_COUNT, 32'd1000 - 32'(43 / (p2 + 1)), 32'h1);
        // auto reload: 30 ticks to zero, reload, 12 more ticks
        bus(1'b1, `PDT_OFF_STAT, 32'h1);
        rd("stat", `PDT_OFF_STAT, 32'h0, 32'h0);
        bus(1'b1, `PDT_OFF_LOAD, 32'd30);
        bus(1'b1, `PDT_OFF_CTRL, 32'h7);
        repeat (40) @(posedge hclk);
        bus(1'b1, `PDT_OFF_CTRL, 32'h6);
        rd("count", `PDT_OFF_COUNT, 32'd18, 32'h1);
        rd("stat", `PDT_OFF_STAT, 32'h1, 32'h0);
        probe_irq(1'b1);
        // clear through the status word itself while the flag is really set
        bus(1'b1, `PDT_OFF_STAT, 32'h1);
        rd("stat", `PDT_OFF_STAT, 32'h0, 32'h0);
        probe_irq(1'b0);
        repeat (5) @(posedge hclk);
        if (notes.size() != 0) begin
            n_errors++;
            $display("ERROR pending notes expected 0 seen %0d", notes.size());
        end
        give_verdict();
    end
endmodule

// File: rtl/pdt_cfg.svh
// Purpose: register map, field positions, reset values and clock figures of the
//          periodic down timer
// Assumes: 32-bit AHB-Lite slave, one aligned word per register
// Notes:   included by bare name; definitions only
`ifndef PDT_CFG_SVH
`define PDT_CFG_SVH

// block placement: 32-byte window at a fixed base
`define PDT_BASE_ADDR   32'hFFFEC600
`define PDT_BASE_MASK   32'hFFFFFFE0

// register byte offsets inside the window
`define PDT_OFF_LOAD    5'h00
`define PDT_OFF_COUNT   5'h04
`define PDT_OFF_CTRL    5'h08
`define PDT_OFF_STAT    5'h0C
`define PDT_OFF_CLR     5'h10
`define PDT_OFF_IEN     5'h14

// timer_control fields
`define PDT_CTRL_EN_BIT   0
`define PDT_CTRL_AUTO_BIT 1
`define PDT_CTRL_IRQ_BIT  2
`define PDT_PRE_LSB       8
`define PDT_PRE_MSB       15
`define PDT_PRE_W         8

// expiry_status / clear / enable layout
`define PDT_STAT_EXP_BIT  0

// reset values
`define PDT_LOAD_RST    32'h00000000
`define PDT_COUNT_RST   32'h00000000
`define PDT_PRE_RST     8'h00

// timer clock before prescaling
`define PDT_CLK_HZ      200000000

`endif

// File: rtl/pdt_pkg.sv
// Purpose: shared types of the periodic down timer
// Assumes: constants live in pdt_cfg.svh
// Notes:   bus state machine is one-hot
package pdt_pkg;

    // bus slave states
    typedef enum logic [1:0] {
        PDT_BUS_IDLE   = 2'b01,
        PDT_BUS_RDWAIT = 2'b10
    } pdt_bus_state_t;

    // decoded register select
    typedef enum logic [2:0] {
        PDT_SEL_NONE  = 3'h0,
        PDT_SEL_LOAD  = 3'h1,
        PDT_SEL_COUNT = 3'h2,
        PDT_SEL_CTRL  = 3'h3,
        PDT_SEL_STAT  = 3'h4,
        PDT_SEL_CLR   = 3'h5,
        PDT_SEL_IEN   = 3'h6
    } pdt_sel_t;

endpackage

// File: rtl/pdt_prescale.sv
// Purpose: prescale divider, one tick every prescale+1 enabled cycles
// Assumes: run and prescale come from registers on hclk
// Notes:   divider freezes while run is low
`timescale 1ns/10ps
`include "pdt_cfg.svh"

module pdt_prescale (
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // control
    input  wire logic                   run,
    input  wire logic [`PDT_PRE_W-1:0]  prescale,
    // decrement strobe
    output logic                        tick
);
    import pdt_pkg::*;

    logic [`PDT_PRE_W-1:0] div_reg;

    // >= so a prescale lowered mid-period still ends the period at once
    assign tick = run && (div_reg >= prescale);

    // divider holds its phase while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= `PDT_PRE_RST;
        end else if (!run) begin
            div_reg <= div_reg;
        end else if (tick) begin
            div_reg <= `PDT_PRE_RST;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

endmodule

// File: rtl/pdt_timer.sv
// Purpose: periodic down timer with AHB-Lite register slave and level interrupt
// Assumes: single slave on the bus, word transfers only, hclk at 200 MHz
// Notes:   writes take no wait state, reads take one wait state
//
// Operation
// - registers sit at a fixed base and accept 32-bit word reads and writes.
// - count_enable one starts counting, zero stops it.
// - while enabled, count decrements on each tick until it reaches zero.
// - reaching zero sets expiry_flag for polling software.
// - writing one clears expiry_flag, writing zero leaves it.
// - with irq_enable set, reaching zero raises the interrupt.
// - with auto_reload zero, counting stops at zero.
// - with auto_reload one, zero reloads start_count and counting continues.
// - present count is readable in current_count.
// - decrement once every prescaler-plus-one clock cycles.
// - counting logic runs on the 200 MHz timer clock before prescaling.
`timescale 1ns/10ps
`include "pdt_cfg.svh"

module pdt_timer (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // interrupt
    output logic             irq
);
    import pdt_pkg::*;

    // bus side state
    pdt_bus_state_t            bus_state_reg;
    pdt_sel_t                  rd_sel_reg;
    pdt_sel_t                  wr_sel_reg;
    logic                      wr_pend_reg;
    logic [31:0]               hrdata_reg;
    logic                      hreadyout_reg;
    logic                      hresp_reg;
    // timer state
    logic [31:0]               load_reg;
    logic [31:0]               count_reg;
    logic                      en_reg;
    logic                      auto_reg;
    logic                      ien_reg;
    logic [`PDT_PRE_W-1:0]     pre_reg;
    logic                      flag_reg;
    logic                      irq_reg;
    // internal strobes
    logic                      aphase;
    logic                      wr_do;
    logic                      wr_load;
    logic                      wr_ctrl;
    logic                      wr_ien;
    logic                      clr_hit;
    logic                      tick;
    logic                      expiry_ev;
    logic [31:0]               rd_word;
    logic [31:0]               ctrl_word;

    // offset decode inside the block window; outside the window selects nothing
    function automatic pdt_sel_t sel_of(input logic [31:0] a);
        pdt_sel_t s;
        s = PDT_SEL_NONE;
        if ((a & `PDT_BASE_MASK) != `PDT_BASE_ADDR) begin
            s = PDT_SEL_NONE;
        end else if (a[4:0] == `PDT_OFF_LOAD) begin
            s = PDT_SEL_LOAD;
        end else if (a[4:0] == `PDT_OFF_COUNT) begin
            s = PDT_SEL_COUNT;
        end else if (a[4:0] == `PDT_OFF_CTRL) begin
            s = PDT_SEL_CTRL;
        end else if (a[4:0] == `PDT_OFF_STAT) begin
            s = PDT_SEL_STAT;
        end else if (a[4:0] == `PDT_OFF_CLR) begin
            s = PDT_SEL_CLR;
        end else if (a[4:0] == `PDT_OFF_IEN) begin
            s = PDT_SEL_IEN;
        end
        return s;
    endfunction

    // outputs straight from flip-flops
    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;
    assign irq       = irq_reg;

    // address phase taken; hsize is not checked, every access acts as a word
    assign aphase  = hsel && htrans[1] && hready;
    assign wr_do   = wr_pend_reg && hready;
    assign wr_load = wr_do && (wr_sel_reg == PDT_SEL_LOAD);
    assign wr_ctrl = wr_do && (wr_sel_reg == PDT_SEL_CTRL);
    assign wr_ien  = wr_do && (wr_sel_reg == PDT_SEL_IEN);
    // status and the clear alias both clear on a one
    assign clr_hit = wr_do && hwdata[`PDT_STAT_EXP_BIT]
                     && ((wr_sel_reg == PDT_SEL_STAT) || (wr_sel_reg == PDT_SEL_CLR));

    // control word as read back
    always_comb begin
        ctrl_word = 32'h00000000;
        ctrl_word[`PDT_CTRL_EN_BIT]             = en_reg;
        ctrl_word[`PDT_CTRL_AUTO_BIT]           = auto_reg;
        ctrl_word[`PDT_CTRL_IRQ_BIT]            = ien_reg;
        ctrl_word[`PDT_PRE_MSB:`PDT_PRE_LSB]    = pre_reg;
    end

    // read mux; clear alias and unmapped offsets read zero
    always_comb begin
        rd_word = 32'h00000000;
        case (rd_sel_reg)
            PDT_SEL_LOAD:  rd_word = load_reg;
            PDT_SEL_COUNT: rd_word = count_reg;
            PDT_SEL_CTRL:  rd_word = ctrl_word;
            PDT_SEL_STAT:  rd_word[`PDT_STAT_EXP_BIT] = flag_reg;
            PDT_SEL_IEN:   rd_word[`PDT_STAT_EXP_BIT] = ien_reg;
            default:       rd_word = 32'h00000000;
        endcase
    end

    // read path: one wait state so a write in the preceding data phase is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= PDT_BUS_IDLE;
            rd_sel_reg    <= PDT_SEL_NONE;
            hrdata_reg    <= 32'h00000000;
            hreadyout_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                PDT_BUS_IDLE: begin
                    if (aphase && !hwrite) begin
                        bus_state_reg <= PDT_BUS_RDWAIT;
                        rd_sel_reg    <= sel_of(haddr);
                        hreadyout_reg <= 1'b0;
                    end
                end
                PDT_BUS_RDWAIT: begin
                    hrdata_reg    <= rd_word;
                    hreadyout_reg <= 1'b1;
                    bus_state_reg <= PDT_BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= PDT_BUS_IDLE;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // write path: capture the address phase, commit when the data phase ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg  <= PDT_SEL_NONE;
        end else if (hready) begin
            wr_pend_reg <= aphase && hwrite;
            wr_sel_reg  <= sel_of(haddr);
        end
    end

    // response is always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
        end
    end

    // start count register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_reg <= `PDT_LOAD_RST;
        end else if (wr_load) begin
            load_reg <= hwdata;
        end
    end

    // control fields; the enable alias shares the irq_enable bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_reg   <= 1'b0;
            auto_reg <= 1'b0;
            ien_reg  <= 1'b0;
            pre_reg  <= `PDT_PRE_RST;
        end else if (wr_ctrl) begin
            en_reg   <= hwdata[`PDT_CTRL_EN_BIT];
            auto_reg <= hwdata[`PDT_CTRL_AUTO_BIT];
            ien_reg  <= hwdata[`PDT_CTRL_IRQ_BIT];
            pre_reg  <= hwdata[`PDT_PRE_MSB:`PDT_PRE_LSB];
        end else if (wr_ien) begin
            ien_reg  <= hwdata[`PDT_STAT_EXP_BIT];
        end
    end

    // prescale divider on the 200 MHz timer clock
    pdt_prescale u_prescale (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .run      (en_reg),
        .prescale (pre_reg),
        .tick     (tick)
    );

    // expiry is the step from one to zero; a load write in that cycle wins
    assign expiry_ev = tick && !wr_load && (count_reg == 32'h00000001);

    // current count; writing start_count also seeds the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `PDT_COUNT_RST;
        end else if (wr_load) begin
            count_reg <= hwdata;
        end else if (tick) begin
            if (count_reg != 32'h00000000) begin
                count_reg <= count_reg - 32'h00000001;
            end else if (auto_reg) begin
                count_reg <= load_reg;
            end else begin
                count_reg <= count_reg;
            end
        end
    end

    // sticky expiry flag; a new expiry beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= 1'b0;
        end else if (expiry_ev) begin
            flag_reg <= 1'b1;
        end else if (clr_hit) begin
            flag_reg <= 1'b0;
        end
    end

    // level interrupt, one cycle behind the flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= flag_reg && ien_reg;
        end
    end

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_read_wait_state: assert property (
        aphase && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (
        aphase && hwrite && hreadyout |=> hreadyout)
        else $error("write inserted a wait state");
    a_enable_starts: assert property (
        wr_ctrl && hwdata[`PDT_CTRL_EN_BIT] |=> en_reg)
        else $error("enable write did not start the timer");
    a_count_decrement: assert property (
        tick && !wr_load && (count_reg != 32'h00000000)
        |=> count_reg == $past(count_reg) - 32'h00000001)
        else $error("count did not decrement on a tick");
    a_flag_on_zero: assert property (
        expiry_ev |=> flag_reg && (count_reg == 32'h00000000))
        else $error("reaching zero did not set the flag");
    a_flag_clear: assert property (
        flag_reg && clr_hit && !expiry_ev |=> !flag_reg ##1 !irq_reg)
        else $error("writing one did not clear the flag and interrupt");
    a_flag_write_zero: assert property (
        flag_reg && wr_do && !hwdata[`PDT_STAT_EXP_BIT] |=> flag_reg)
        else $error("writing zero changed the flag");
    a_irq_raise: assert property (
        expiry_ev && ien_reg && !wr_ctrl && !wr_ien |=> ##1 irq_reg)
        else $error("enabled expiry raised no interrupt");
    a_irq_level: assert property (
        irq_reg |-> $past(flag_reg) && $past(ien_reg))
        else $error("interrupt high without flag and enable");
    a_stop_at_zero: assert property (
        en_reg && !auto_reg && !wr_load && (count_reg == 32'h00000000) |=>
        count_reg == 32'h00000000)
        else $error("non-reloading timer left zero");
    a_auto_reload: assert property (
        tick && auto_reg && !wr_load && (count_reg == 32'h00000000)
        |=> count_reg == $past(load_reg))
        else $error("auto reload did not copy start_count");
    a_count_readback: assert property (
        bus_state_reg == PDT_BUS_RDWAIT && rd_sel_reg == PDT_SEL_COUNT
        |=> hrdata == $past(count_reg))
        else $error("current_count read returned a wrong value");
    // a control write right after the tick may legally move the prescale
    a_prescale_gap: assert property (
        tick && (pre_reg == 8'h01) && !wr_ctrl |=> !tick ##1
        (tick || !en_reg || wr_ctrl || $past(wr_ctrl)))
        else $error("prescale one did not tick every second cycle");
    a_hold_disabled: assert property (
        !en_reg && !wr_load |=> $stable(count_reg) && !$past(tick))
        else $error("disabled timer moved");

    c_expiry_polled: cover property (expiry_ev ##[1:20] clr_hit);
    c_auto_reload: cover property (tick && auto_reg && count_reg == 32'h00000000);
    c_irq_raised: cover property ($rose(irq_reg));
    c_set_beats_clear: cover property (expiry_ev && clr_hit);

endmodule
